// ===== pkg/reset_power_pkg.sv
// Constants for the reset generator, power switch and oscillator output logic
// Operation
// R1: Clear output stays low 5.6 ms after supply above 3.5V and clock running, then high.
// R2: External active-low reset input low forces the clear output low.
// R3: A USB bus reset leaves the clear output untouched.
// R4: External reset input is active low; unused, the board holds it high.
// R5: During reset the prom pins float; outside reset the prom clock is driven.
// R6: Power switch output goes low once configured, high again during suspend.
// R7: Oscillator output stops toggling while USB suspend is in effect.
// R8: Board keeps the factory test input low; high selects manufacturing test mode. Here the input is only registered onto test_mode_o.
// R9: Reference clock is 6 MHz, from a crystal or an external source.
// R10: Working clock is the reference multiplied by eight.
// R11: Release of the external reset restarts the full clear output low time.
package reset_power_pkg;

    // Clock of this logic
    localparam int unsigned CLK_PERIOD_NS = 100;

    // Reference and working clock rates
    localparam int unsigned REF_CLK_HZ    = 6_000_000;
    localparam int unsigned CLK_MULT      = 8;
    localparam int unsigned WORK_CLK_HZ   = REF_CLK_HZ * CLK_MULT;

    // Supply qualification threshold, in millivolts, applied by the analog comparator
    localparam int unsigned SUPPLY_QUAL_MV = 3500;

    // Clear output low time; a least time, so the cycle count rounds up
    localparam int unsigned LOW_TIME_NS   = 5_600_000;
    localparam int unsigned LOW_CYCLES    = (LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 17;

    // Reset values of the pin registers
    localparam logic CLEAR_OUT_RST  = 1'b0;
    localparam logic POWER_OFF      = 1'b1;
    localparam logic OE_N_FLOAT     = 1'b1;
    localparam logic OSC_OUT_RST    = 1'b0;

    // Sequencer states, Gray coded along wait, count, run
    typedef enum logic [1:0] {
        ST_WAIT  = 2'b00,
        ST_COUNT = 2'b01,
        ST_RUN   = 2'b11
    } seq_state_t;

endpackage

// ===== core/osc_gate.sv
// Oscillator output stage that freezes during suspend
`timescale 1ns/1ns
module osc_gate (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic osc_in_i,
    input  wire logic hold_i,
    output logic      osc_out_o
);

    logic osc_reg;
    logic osc_next;

    // Follow the reference, or hold the last level; downstream logic sees a stopped clock
    always_comb begin
        osc_next = osc_reg;
        if (!hold_i) begin
            osc_next = osc_in_i; // R9
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_reg <= reset_power_pkg::OSC_OUT_RST;
        end else begin
            osc_reg <= osc_next;
        end
    end

    assign osc_out_o = osc_reg;

    property p_osc_frozen;
        @(posedge clk_i) disable iff (rst_i)
        hold_i |=> $stable(osc_out_o);
    endproperty
    a_osc_frozen: assert property (p_osc_frozen) // R7
        else $error("Oscillator output moved during suspend");

    property p_osc_follows;
        @(posedge clk_i) disable iff (rst_i)
        !hold_i |=> (osc_out_o == $past(osc_in_i));
    endproperty
    a_osc_follows: assert property (p_osc_follows) // R9
        else $error("Oscillator output did not follow the reference");

endmodule

// ===== core/reset_power_ctrl.sv
// Reset generator, prom pin control, power switch output and oscillator output
`timescale 1ns/1ns
module reset_power_ctrl #(
    parameter int unsigned LOW_CYCLES = reset_power_pkg::LOW_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic supply_ok_i,
    input  wire logic pll_lock_i,
    input  wire logic reset_in_n_i,
    input  wire logic usb_bus_reset_i,
    input  wire logic usb_configured_i,
    input  wire logic usb_suspend_i,
    input  wire logic test_mode_i,
    input  wire logic osc_in_i,
    input  wire logic engine_select_i,
    input  wire logic engine_sclk_i,
    input  wire logic engine_dout_i,
    input  wire logic engine_dout_en_i,
    input  wire logic prom_data_io_i,
    output logic      generator_clear_out_n_o,
    output logic      prom_select_o,
    output logic      prom_select_oe_n_o,
    output logic      prom_serial_clock_o,
    output logic      prom_serial_clock_oe_n_o,
    output logic      prom_data_io_o,
    output logic      prom_data_io_oe_n_o,
    output logic      prom_data_in_o,
    output logic      power_switch_on_n_o,
    output logic      test_mode_o,
    output logic      osc_out_o
);

    localparam int unsigned W = reset_power_pkg::CNT_W;

    reset_power_pkg::seq_state_t state_reg;
    reset_power_pkg::seq_state_t state_next;
    logic [W-1:0]                cnt_reg;
    logic [W-1:0]                cnt_next;
    logic                        clear_reg;
    logic                        clear_next;
    logic                        qual_ok;
    logic                        run_next;

    logic                        sel_reg;
    logic                        sel_next;
    logic                        sel_oe_n_reg;
    logic                        sel_oe_n_next;
    logic                        sclk_reg;
    logic                        sclk_next;
    logic                        sclk_oe_n_reg;
    logic                        sclk_oe_n_next;
    logic                        dout_reg;
    logic                        dout_next;
    logic                        dout_oe_n_reg;
    logic                        dout_oe_n_next;
    logic                        din_reg;
    logic                        din_next;

    logic                        pwr_n_reg;
    logic                        pwr_n_next;
    logic                        test_reg;
    logic                        test_next;

    // Supply above threshold, multiplied clock locked, external reset released
    assign qual_ok = supply_ok_i && pll_lock_i && reset_in_n_i; // R1 R2 R4 R10

    // Sequencer; the USB bus reset is deliberately not an input to it
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            reset_power_pkg::ST_WAIT: begin
                cnt_next = '0;
                if (qual_ok) begin
                    state_next = reset_power_pkg::ST_COUNT; // R11
                end
            end
            reset_power_pkg::ST_COUNT: begin
                if (!qual_ok) begin
                    state_next = reset_power_pkg::ST_WAIT; // R2
                    cnt_next   = '0;
                end else if (cnt_reg == W'(LOW_CYCLES - 1)) begin
                    state_next = reset_power_pkg::ST_RUN; // R1
                end else begin
                    cnt_next = cnt_reg + W'(1);
                end
            end
            reset_power_pkg::ST_RUN: begin
                if (!qual_ok) begin
                    state_next = reset_power_pkg::ST_WAIT; // R2
                end
            end
            default: begin
                state_next = reset_power_pkg::ST_WAIT;
                cnt_next   = '0;
            end
        endcase
        run_next   = (state_next == reset_power_pkg::ST_RUN);
        clear_next = run_next; // R1 R3
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= reset_power_pkg::ST_WAIT;
            cnt_reg   <= '0;
            clear_reg <= reset_power_pkg::CLEAR_OUT_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            clear_reg <= clear_next;
        end
    end

    // Prom pins float in reset so the pull-ups hold them; enables change with the clear output
    always_comb begin
        sel_next       = engine_select_i;
        sclk_next      = engine_sclk_i;
        dout_next      = engine_dout_i;
        din_next       = prom_data_io_i;
        sel_oe_n_next  = reset_power_pkg::OE_N_FLOAT;
        sclk_oe_n_next = reset_power_pkg::OE_N_FLOAT;
        dout_oe_n_next = reset_power_pkg::OE_N_FLOAT;
        if (run_next) begin
            sel_oe_n_next  = 1'b0;
            sclk_oe_n_next = 1'b0; // R5
            dout_oe_n_next = !engine_dout_en_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_reg       <= 1'b0;
            sclk_reg      <= 1'b0;
            dout_reg      <= 1'b0;
            din_reg       <= 1'b0;
            sel_oe_n_reg  <= reset_power_pkg::OE_N_FLOAT; // R5
            sclk_oe_n_reg <= reset_power_pkg::OE_N_FLOAT;
            dout_oe_n_reg <= reset_power_pkg::OE_N_FLOAT;
        end else begin
            sel_reg       <= sel_next;
            sclk_reg      <= sclk_next;
            dout_reg      <= dout_next;
            din_reg       <= din_next;
            sel_oe_n_reg  <= sel_oe_n_next;
            sclk_oe_n_reg <= sclk_oe_n_next;
            dout_oe_n_reg <= dout_oe_n_next;
        end
    end

    // Power switch on only when running, configured and awake; test input is just flagged
    always_comb begin
        pwr_n_next = reset_power_pkg::POWER_OFF;
        if (run_next && usb_configured_i && !usb_suspend_i) begin
            pwr_n_next = 1'b0; // R6
        end
        test_next = test_mode_i;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_n_reg <= reset_power_pkg::POWER_OFF;
            test_reg  <= 1'b0;
        end else begin
            pwr_n_reg <= pwr_n_next;
            test_reg  <= test_next;
        end
    end

    // Oscillator output freezes in suspend; external logic on it must live with that
    osc_gate u_osc_gate (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .osc_in_i  (osc_in_i),
        .hold_i    (usb_suspend_i), // R7
        .osc_out_o (osc_out_o)
    );

    assign generator_clear_out_n_o  = clear_reg;
    assign prom_select_o            = sel_reg;
    assign prom_select_oe_n_o       = sel_oe_n_reg;
    assign prom_serial_clock_o      = sclk_reg;
    assign prom_serial_clock_oe_n_o = sclk_oe_n_reg;
    assign prom_data_io_o           = dout_reg;
    assign prom_data_io_oe_n_o      = dout_oe_n_reg;
    assign prom_data_in_o           = din_reg;
    assign power_switch_on_n_o      = pwr_n_reg;
    assign test_mode_o              = test_reg;

    // Qualified low cycles seen before the clear output rises; checks the low time
    logic [W-1:0] hold_cnt_reg;
    logic [W-1:0] hold_cnt_next;

    always_comb begin
        hold_cnt_next = '0;
        if (qual_ok && !generator_clear_out_n_o) begin
            hold_cnt_next = hold_cnt_reg + W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_cnt_reg <= '0;
        end else begin
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    property p_low_time;
        @(posedge clk_i) disable iff (rst_i)
        $rose(generator_clear_out_n_o) |-> ($past(hold_cnt_reg) >= W'(LOW_CYCLES));
    endproperty
    a_low_time: assert property (p_low_time) // R1
        else $error("Clear output released before the low time ran out");

    property p_supply_low;
        @(posedge clk_i) disable iff (rst_i)
        !supply_ok_i |=> !generator_clear_out_n_o;
    endproperty
    a_supply_low: assert property (p_supply_low) // R1
        else $error("Clear output high without a qualified supply");

    property p_ext_reset;
        @(posedge clk_i) disable iff (rst_i)
        !reset_in_n_i |=> !generator_clear_out_n_o;
    endproperty
    a_ext_reset: assert property (p_ext_reset) // R2
        else $error("External reset did not force the clear output low");

    property p_bus_reset;
        @(posedge clk_i) disable iff (rst_i)
        (usb_bus_reset_i && generator_clear_out_n_o && qual_ok) |=> generator_clear_out_n_o;
    endproperty
    a_bus_reset: assert property (p_bus_reset) // R3
        else $error("USB bus reset disturbed the clear output");

    property p_prom_float;
        @(posedge clk_i) disable iff (rst_i)
        !generator_clear_out_n_o |-> (prom_select_oe_n_o && prom_serial_clock_oe_n_o && prom_data_io_oe_n_o);
    endproperty
    a_prom_float: assert property (p_prom_float) // R5
        else $error("Prom pin driven during reset");

    property p_prom_clock;
        @(posedge clk_i) disable iff (rst_i)
        generator_clear_out_n_o |-> !prom_serial_clock_oe_n_o;
    endproperty
    a_prom_clock: assert property (p_prom_clock) // R5
        else $error("Prom clock not driven outside reset");

    property p_power_on;
        @(posedge clk_i) disable iff (rst_i)
        (generator_clear_out_n_o && qual_ok && usb_configured_i && !usb_suspend_i) |=> !power_switch_on_n_o;
    endproperty
    a_power_on: assert property (p_power_on) // R6
        else $error("Power switch not on after configuration");

    property p_power_suspend;
        @(posedge clk_i) disable iff (rst_i)
        usb_suspend_i |=> power_switch_on_n_o;
    endproperty
    a_power_suspend: assert property (p_power_suspend) // R6
        else $error("Power switch left on during suspend");

    property p_restart;
        @(posedge clk_i) disable iff (rst_i)
        ($rose(reset_in_n_i) && supply_ok_i && pll_lock_i) |=> !generator_clear_out_n_o [*2];
    endproperty
    a_restart: assert property (p_restart) // R11
        else $error("Clear output rose straight after external reset release");

    property p_lock;
        @(posedge clk_i) disable iff (rst_i)
        !pll_lock_i |=> !generator_clear_out_n_o;
    endproperty
    a_lock: assert property (p_lock) // R10
        else $error("Clear output high before the multiplied clock locked");

endmodule

// ===== verification/board_model.sv
// Board side model: external reset source, test strap, 6 MHz source and prom data line
`timescale 1ns/1ns
module board_model (
    input  wire logic ext_reset_req_i,
    input  wire logic prom_data_io_i,
    input  wire logic prom_data_io_oe_n_i,
    output logic      reset_in_n_o,
    output logic      test_mode_o,
    output logic      osc_in_o,
    output logic      prom_line_o
);
    // Reset input stays high unless the bench asks for an external reset
    assign reset_in_n_o = ~ext_reset_req_i;
    // Test strap kept low for normal operation
    assign test_mode_o = 1'b0;
    // A released data line falls to its pull-up level
    assign prom_line_o = prom_data_io_oe_n_i ? 1'b1 : prom_data_io_i;
    // 6 MHz source; an edge landing on a rising bench clock edge slips 1 ns so sampling never races
    initial begin
        osc_in_o = 1'b0;
        forever begin
            #83;
            if ($time % 100 == 50) begin
                #1;
            end
            osc_in_o = ~osc_in_o;
        end
    end
endmodule

// ===== verification/reset_and_power_state_signalling_tb_top.sv
// Self-checking testbench for the reset generator, prom pins, power switch and oscillator output
`timescale 1ns/1ns
module reset_and_power_state_signalling_tb_top;
    localparam int unsigned LOWC = 8;
    typedef struct packed {
        logic       clr;
        logic       pwr_n;
        logic [2:0] oe_n;
        logic [2:0] val;
        logic       osc;
        logic       tst;
        logic       din;
    } note_t;
    logic  clk_i, rst_i, supply_ok, pll_lock, ext_req, bus_rst, cfg, susp;
    logic  sel, sclk, dout, dout_en, reset_in_n, test_mode, osc_in, prom_line, osc_exp;
    logic  clr_o, sel_o, sel_oe_n, sclk_o, sclk_oe_n, d_o, d_oe_n, pwr_n_o, tst_o, osc_o, din_o, line_exp;
    logic  [31:0] rnd;
    int    bad_count, n_tests;
    note_t q[$];
    note_t e, a;

    reset_power_ctrl #(.LOW_CYCLES(LOWC)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok),
        .pll_lock_i(pll_lock), .reset_in_n_i(reset_in_n), .usb_bus_reset_i(bus_rst),
        .usb_configured_i(cfg), .usb_suspend_i(susp), .test_mode_i(test_mode), .osc_in_i(osc_in),
        .engine_select_i(sel), .engine_sclk_i(sclk), .engine_dout_i(dout), .engine_dout_en_i(dout_en),
        .prom_data_io_i(prom_line), .generator_clear_out_n_o(clr_o), .prom_select_o(sel_o),
        .prom_select_oe_n_o(sel_oe_n), .prom_serial_clock_o(sclk_o), .prom_serial_clock_oe_n_o(sclk_oe_n),
        .prom_data_io_o(d_o), .prom_data_io_oe_n_o(d_oe_n), .prom_data_in_o(din_o), .power_switch_on_n_o(pwr_n_o),
        .test_mode_o(tst_o), .osc_out_o(osc_o));

    board_model model_u (.ext_reset_req_i(ext_req), .prom_data_io_i(d_o), .prom_data_io_oe_n_i(d_oe_n),
        .reset_in_n_o(reset_in_n), .test_mode_o(test_mode), .osc_in_o(osc_in), .prom_line_o(prom_line));

    // Free running bench clock, 100 ns period
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Expected oscillator output: follows the source, frozen while suspended
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_exp <= 1'b0;
        end else if (!susp) begin
            osc_exp <= osc_in;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Note what the outputs must show after this edge, from the inputs it samples; the data line
    // read back is what the previous edge left on it, the pull-up level while released
    task automatic tick(input logic c);
        note_t n;
        @(posedge clk_i);
        #1;
        n = '{c, ~(c & cfg & ~susp), {~c, ~c, ~(c & dout_en)}, {sel, sclk, dout}, osc_exp, 1'b0, line_exp};
        line_exp = n.oe_n[0] | n.val[0];
        q.push_back(n);
        #9;
    endtask

    // Full low time of the clear output, then release
    task automatic count_up();
        for (int i = 1; i <= LOWC + 1; i++) begin
            tick(i == LOWC + 1);
        end
    endtask

    task automatic set_qual(input int j, input logic v);
        case (j)
            0: supply_ok = v;
            1: pll_lock = v;
            default: ext_req = ~v;
        endcase
    endtask

    task automatic done(input string name);
        $display("test %s done: %0d compares, %0d mismatches", name, n_tests, bad_count);
    endtask

    task automatic results();
        $display("compares %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watcher: takes the oldest note once the edge's outputs have settled
    always @(negedge clk_i) begin
        if (q.size() > 0) begin
            e = q.pop_front();
            a = '{clr_o, pwr_n_o, {sel_oe_n, sclk_oe_n, d_oe_n}, {sel_o, sclk_o, d_o}, osc_o, tst_o, din_o};
            if (!e.clr) begin
                a.val = e.val; // Pin values are don't-care while the clear output is low and the pins float
            end
            n_tests++;
            if (a !== e) begin
                bad_count++;
                $display("mismatch at %0t: outputs %b, expected %b", $time, a, e);
            end
        end
    end

    // Watchdog, far beyond the under a hundred cycles the sequence needs
    initial begin
        #(3000 * 100);
        bad_count++;
        $display("mismatch at %0t: run did not finish", $time);
        results();
    end

    initial begin
        {supply_ok, pll_lock, ext_req, bus_rst, susp, sel, sclk, dout} = 8'h00;
        {rst_i, cfg, dout_en} = 3'h7;
        bad_count = 0;
        n_tests = 0;
        rnd = 32'h7a6b;
        line_exp = 1'b1; // Data line released in reset reads as the pull-up level
        repeat (5) @(posedge clk_i);
        #10 rst_i = 1'b0;
        tick(1'b0);
        supply_ok = 1'b1;
        pll_lock = 1'b1;
        count_up();
        done("power-up");
        // Each qualifier dropped when running and again in mid-count
        for (int j = 0; j < 3; j++) begin
            set_qual(j, 1'b0);
            tick(1'b0);
            set_qual(j, 1'b1);
            repeat (3) tick(1'b0);
            set_qual(j, 1'b0);
            tick(1'b0);
            set_qual(j, 1'b1);
            count_up();
        end
        done("qualifier drops");
        bus_rst = 1'b1;
        repeat (4) tick(1'b1);
        bus_rst = 1'b0;
        done("bus reset");
        // Random engine values, configuration and suspend while running
        repeat (24) begin
            rnd = xs(rnd);
            {sel, sclk, dout, dout_en, susp, cfg} = rnd[5:0];
            tick(1'b1);
        end
        done("random pins");
        cfg = 1'b1;
        susp = 1'b1;
        repeat (6) tick(1'b1);
        susp = 1'b0;
        repeat (2) tick(1'b1);
        done("suspend");
        repeat (2) @(posedge clk_i);
        results();
    end
endmodule
